// file: rtl/ptg_pulse_train.sv
// Summary of operation
// - each channel outputs a square wave or a repeating 2 to 32 bit pattern
// - channels started together advance bits in exact lockstep
// - each channel has its own pattern, length, rate and repeat registers
// - per-channel start and stop via write-one bits, no read-modify-write
// - one start write can launch a single channel or an aligned group
// - bit rate is module clock divided by a per-channel power of two
// - module clock may come from a separate source, selected by a control bit
// - single shot emits the pattern exactly once
// - pattern replays a programmed number of times, or forever with zero
// - finishing a loop count can restart other selected channels
// - the channel output always drives the pin; the pin function enable is only passed out on pinFuncEn
// - sixteen channels, numbered 0 to 15
`timescale 1ns/10ps
`default_nettype none
module ptg_pulse_train #(
   parameter int unsigned CHANNELS = ptg_pkg::PTG_CHANNELS
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  resetn,
   // axi4-lite write address
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [11:0]           awaddr,
   input  wire logic [2:0]            awprot,
   // axi4-lite write data
   input  wire logic                  wvalid,
   output logic                       wready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   // axi4-lite write response
   output logic                       bvalid,
   input  wire logic                  bready,
   output logic [1:0]                 bresp,
   // axi4-lite read address
   input  wire logic                  arvalid,
   output logic                       arready,
   input  wire logic [11:0]           araddr,
   input  wire logic [2:0]            arprot,
   // axi4-lite read data
   output logic                       rvalid,
   input  wire logic                  rready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   // alternate module clock pin
   input  wire logic                  moduleClkPin,
   // pins and interrupt
   output logic [CHANNELS-1:0]        pulse_train_outputs,
   output logic [CHANNELS-1:0]        pinFuncEn,
   output logic                       irq
);
   logic                awHeld_q, wHeld_q, bvalid_q, rvalid_q;
   logic                awReady_q, wReady_q, arReady_q, awHeld_d, wHeld_d, bvalid_d;
   logic [11:0]         awAddr_q;
   logic [31:0]         wData_q, rdata_q;
   logic [3:0]          wStrb_q;
   logic [1:0]          bresp_q, rresp_q;
   logic                wrFire;
   logic [31:0]         strbMask, wrVal;
   logic                ctrlClkSel_q;
   logic [CHANNELS-1:0] intEn_q, pinEn_q, status_q, outs_q;
   logic                irq_q;
   logic                pinSync1_q, pinSync2_q, pinSync3_q, modEn;
   logic [CHANNELS-1:0] running, chanOut, doneVec, swStart, swStop, restartVec, intClr;
   logic [31:0]         cfg_q [CHANNELS];
   logic [31:0]         pattern_q [CHANNELS];
   logic [31:0]         loops_q [CHANNELS];
   logic [31:0]         rdVal;
   logic                rdOk, wrOk;
   logic [3:0]          rdCh, wrCh;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data taken in either order, one write at a time
   assign awready = awReady_q;
   assign wready  = wReady_q;
   assign arready = arReady_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign wrFire  = awHeld_q && wHeld_q && !bvalid_q;
   assign awHeld_d = (awvalid && awready) || (awHeld_q && !wrFire);
   assign wHeld_d  = (wvalid && wready) || (wHeld_q && !wrFire);
   assign bvalid_d = wrFire || (bvalid_q && !bready);
   assign strbMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
   assign wrVal   = wData_q & strbMask;
   assign wrCh    = awAddr_q[7:4];
   assign rdCh    = araddr[7:4];

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 12'h000;
      end else if (awvalid && awready) begin
         awHeld_q <= 1'b1;
         awAddr_q <= awaddr;
      end else if (wrFire) begin
         awHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wHeld_q <= 1'b0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld_q <= 1'b1;
         wData_q <= wdata;
         wStrb_q <= wstrb;
      end else if (wrFire) begin
         wHeld_q <= 1'b0;
      end
   end

   always_comb begin
      wrOk = 1'b1;
      case (awAddr_q)
         ptg_pkg::PTG_OFF_CTRL, ptg_pkg::PTG_OFF_START, ptg_pkg::PTG_OFF_STOP,
         ptg_pkg::PTG_OFF_INTEN, ptg_pkg::PTG_OFF_INTCLR, ptg_pkg::PTG_OFF_PINEN: wrOk = 1'b1;
         default: begin
            wrOk = (awAddr_q[11:8] == ptg_pkg::PTG_OFF_CHBASE[11:8]) && (32'(wrCh) < CHANNELS)
                   && (awAddr_q[3:0] <= ptg_pkg::PTG_OFF_LOOPS) && (awAddr_q[1:0] == 2'b00);
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= ptg_pkg::PTG_RESP_OKAY;
      end else if (wrFire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wrOk ? ptg_pkg::PTG_RESP_OKAY : ptg_pkg::PTG_RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ready is built from next state so it leaves a flop with no path from the bus inputs
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         awReady_q <= 1'b1;
         wReady_q  <= 1'b1;
      end else begin
         awReady_q <= !awHeld_d && !bvalid_d;
         wReady_q  <= !wHeld_d && !bvalid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrlClkSel_q <= 1'b0;
      end else if (wrFire && awAddr_q == ptg_pkg::PTG_OFF_CTRL && wStrb_q[0]) begin
         ctrlClkSel_q <= wData_q[ptg_pkg::PTG_CTRL_CLKSEL];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         intEn_q <= '0;
      end else if (wrFire && awAddr_q == ptg_pkg::PTG_OFF_INTEN) begin
         intEn_q <= (intEn_q & ~strbMask[CHANNELS-1:0]) | wrVal[CHANNELS-1:0];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pinEn_q <= '0;
      end else if (wrFire && awAddr_q == ptg_pkg::PTG_OFF_PINEN) begin
         pinEn_q <= (pinEn_q & ~strbMask[CHANNELS-1:0]) | wrVal[CHANNELS-1:0];
      end
   end

   // write-one bits touch only the named channels, so no read-modify-write
   assign swStart = (wrFire && awAddr_q == ptg_pkg::PTG_OFF_START) ? wrVal[CHANNELS-1:0] : '0;
   assign swStop  = (wrFire && awAddr_q == ptg_pkg::PTG_OFF_STOP) ? wrVal[CHANNELS-1:0] : '0;
   assign intClr  = (wrFire && awAddr_q == ptg_pkg::PTG_OFF_INTCLR) ? wrVal[CHANNELS-1:0] : '0;

   // a completion landing with its clear keeps the flag
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~intClr) | doneVec;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(((status_q & ~intClr) | doneVec) & intEn_q);
      end
   end
   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // module clock select: system clock, or rising edges of the synchronised pin;
   // the pin must run below half the system clock or edges get lost
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pinSync1_q <= 1'b0;
         pinSync2_q <= 1'b0;
         pinSync3_q <= 1'b0;
      end else begin
         pinSync1_q <= moduleClkPin;
         pinSync2_q <= pinSync1_q;
         pinSync3_q <= pinSync2_q;
      end
   end
   assign modEn = ctrlClkSel_q ? (pinSync2_q && !pinSync3_q) : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // finished channels fire the restart masks of others
   always_comb begin
      restartVec = '0;
      for (int j = 0; j < CHANNELS; j++) begin
         if (doneVec[j]) begin
            restartVec = restartVec | loops_q[j][ptg_pkg::PTG_LOOPS_RSTRT +: CHANNELS];
         end
      end
   end

   for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            cfg_q[i]     <= ptg_pkg::PTG_CFG_RST;
            pattern_q[i] <= ptg_pkg::PTG_PATTERN_RST;
            loops_q[i]   <= ptg_pkg::PTG_LOOPS_RST;
         end else if (wrFire && wrOk && awAddr_q[11:8] == ptg_pkg::PTG_OFF_CHBASE[11:8]
                      && wrCh == 4'(i)) begin
            case (awAddr_q[3:0])
               ptg_pkg::PTG_OFF_CFG:     cfg_q[i]     <= (cfg_q[i] & ~strbMask) | wrVal;
               ptg_pkg::PTG_OFF_PATTERN: pattern_q[i] <= (pattern_q[i] & ~strbMask) | wrVal;
               ptg_pkg::PTG_OFF_LOOPS:   loops_q[i]   <= (loops_q[i] & ~strbMask) | wrVal;
               default: begin
                  cfg_q[i] <= cfg_q[i];
               end
            endcase
         end
      end

      ptg_channel u_chan (
         .clock      (clock),
         .resetn     (resetn),
         .modEn      (modEn),
         .start      (swStart[i] | restartVec[i]),
         .stop       (swStop[i]),
         .squareMode (cfg_q[i][ptg_pkg::PTG_CFG_SQUARE]),
         .rateSel    (cfg_q[i][ptg_pkg::PTG_CFG_RATE +: ptg_pkg::PTG_RATE_W]),
         .lastBit    (cfg_q[i][ptg_pkg::PTG_CFG_LAST +: 5]),
         .pattern    (pattern_q[i]),
         .loopCount  (loops_q[i][ptg_pkg::PTG_LOOPS_CNT +: ptg_pkg::PTG_LOOP_W]),
         .running    (running[i]),
         .chanOut    (chanOut[i]),
         .done       (doneVec[i])
      );
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         outs_q <= '0;
      end else begin
         outs_q <= chanOut;
      end
   end
   assign pulse_train_outputs = outs_q;
   assign pinFuncEn           = pinEn_q;

   ////////////////////////////////////////////////////////////////////////////
   // read side: one cycle from address to data
   always_comb begin
      rdVal = 32'h0000_0000;
      rdOk  = 1'b1;
      case (araddr)
         ptg_pkg::PTG_OFF_CTRL:    rdVal = {31'h0000_0000, ctrlClkSel_q};
         ptg_pkg::PTG_OFF_RUNNING: rdVal = 32'(running);
         ptg_pkg::PTG_OFF_START, ptg_pkg::PTG_OFF_STOP, ptg_pkg::PTG_OFF_INTCLR: rdVal = 32'h0000_0000;
         ptg_pkg::PTG_OFF_INTSTAT: rdVal = 32'(status_q);
         ptg_pkg::PTG_OFF_INTEN:   rdVal = 32'(intEn_q);
         ptg_pkg::PTG_OFF_PINEN:   rdVal = 32'(pinEn_q);
         default: begin
            rdOk = (araddr[11:8] == ptg_pkg::PTG_OFF_CHBASE[11:8]) && (32'(rdCh) < CHANNELS)
                   && (araddr[1:0] == 2'b00);
            if (rdOk) begin
               case (araddr[3:0])
                  ptg_pkg::PTG_OFF_CFG:     rdVal = cfg_q[rdCh];
                  ptg_pkg::PTG_OFF_PATTERN: rdVal = pattern_q[rdCh];
                  ptg_pkg::PTG_OFF_LOOPS:   rdVal = loops_q[rdCh];
                  default:                  rdOk  = 1'b0;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rvalid_q  <= 1'b0;
         arReady_q <= 1'b1;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= ptg_pkg::PTG_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q  <= 1'b1;
         arReady_q <= 1'b0;
         rdata_q   <= rdVal;
         rresp_q   <= rdOk ? ptg_pkg::PTG_RESP_OKAY : ptg_pkg::PTG_RESP_SLVERR;
      end else if (rready) begin
         rvalid_q  <= 1'b0;
         arReady_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_status_set_wins: assert property (@(posedge clock) disable iff (!resetn)
      (|doneVec) |=> ((status_q & $past(doneVec)) == $past(doneVec)))
      else $error("completion flag lost");

   a_done_stops_chan: assert property (@(posedge clock) disable iff (!resetn)
      (|doneVec) |-> ((running & doneVec & ~restartVec) == '0))
      else $error("finished channel still running");

   a_restart_launch: assert property (@(posedge clock) disable iff (!resetn)
      (|(restartVec & ~swStop)) |=> ((running & $past(restartVec & ~swStop)) == $past(restartVec & ~swStop)))
      else $error("restart target not launched");

   a_pin_follows: assert property (@(posedge clock) disable iff (!resetn)
      ##1 pulse_train_outputs == $past(chanOut))
      else $error("pin output does not follow channel");

   a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
      ((status_q & intEn_q) != '0 && intClr == '0) |=> irq)
      else $error("enabled flag without interrupt");

   a_stop_wins: assert property (@(posedge clock) disable iff (!resetn)
      (|swStop) |=> ((running & $past(swStop)) == '0))
      else $error("stopped channel still running");

   a_group_start: assert property (@(posedge clock) disable iff (!resetn)
      (|swStart && swStop == '0) |=> ((running & $past(swStart)) == $past(swStart)))
      else $error("group start missed a channel");
endmodule : ptg_pulse_train
`default_nettype wire

// file: include/ptg_pkg.sv
`default_nettype none
package ptg_pkg;
   // bank size and register geometry
   localparam int unsigned PTG_CHANNELS   = 16;
   localparam int unsigned PTG_ADDR_W     = 12;
   localparam int unsigned PTG_RATE_W     = 4;
   localparam int unsigned PTG_DIV_W      = 16;
   localparam int unsigned PTG_LOOP_W     = 16;
   localparam int unsigned PTG_IDX_W      = 5;
   ////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [11:0] PTG_OFF_CTRL    = 12'h000;
   localparam logic [11:0] PTG_OFF_RUNNING = 12'h004;
   localparam logic [11:0] PTG_OFF_START   = 12'h008;
   localparam logic [11:0] PTG_OFF_STOP    = 12'h00c;
   localparam logic [11:0] PTG_OFF_INTSTAT = 12'h010;
   localparam logic [11:0] PTG_OFF_INTEN   = 12'h014;
   localparam logic [11:0] PTG_OFF_INTCLR  = 12'h018;
   localparam logic [11:0] PTG_OFF_PINEN   = 12'h01c;
   localparam logic [11:0] PTG_OFF_CHBASE  = 12'h100;
   localparam logic [3:0]  PTG_OFF_CFG     = 4'h0;
   localparam logic [3:0]  PTG_OFF_PATTERN = 4'h4;
   localparam logic [3:0]  PTG_OFF_LOOPS   = 4'h8;
   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned PTG_CTRL_CLKSEL = 0;
   localparam int unsigned PTG_CFG_RATE    = 0;
   localparam int unsigned PTG_CFG_SQUARE  = 4;
   localparam int unsigned PTG_CFG_LAST    = 8;
   localparam int unsigned PTG_LOOPS_CNT   = 0;
   localparam int unsigned PTG_LOOPS_RSTRT = 16;
   ////////////////////////////////////////////////////////////////////////////
   // reset values and fixed patterns
   localparam logic [31:0] PTG_CFG_RST     = 32'h0000_1f00;
   localparam logic [31:0] PTG_PATTERN_RST = 32'h0000_0000;
   localparam logic [31:0] PTG_LOOPS_RST   = 32'h0000_0000;
   localparam logic [31:0] PTG_SQ_PATTERN  = 32'h0000_0002;
   localparam logic [4:0]  PTG_SQ_LAST     = 5'h01;
   localparam logic [4:0]  PTG_MIN_LAST    = 5'h01;
   ////////////////////////////////////////////////////////////////////////////
   // bus answers and channel states
   localparam logic [1:0]  PTG_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  PTG_RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      PTG_IDLE  = 3'b001,
      PTG_RUN   = 3'b010,
      PTG_DRAIN = 3'b100
   } ptg_state_e;
endpackage : ptg_pkg
`default_nettype wire

// file: rtl/ptg_channel.sv
`timescale 1ns/10ps
`default_nettype none
module ptg_channel #(
   parameter int unsigned RATE_W = ptg_pkg::PTG_RATE_W,
   parameter int unsigned DIV_W  = ptg_pkg::PTG_DIV_W,
   parameter int unsigned LOOP_W = ptg_pkg::PTG_LOOP_W
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              resetn,
   // control
   input  wire logic              modEn,
   input  wire logic              start,
   input  wire logic              stop,
   // configuration
   input  wire logic              squareMode,
   input  wire logic [RATE_W-1:0] rateSel,
   input  wire logic [4:0]        lastBit,
   input  wire logic [31:0]       pattern,
   input  wire logic [LOOP_W-1:0] loopCount,
   // status and output
   output logic                   running,
   output logic                   chanOut,
   output logic                   done
);
   ptg_pkg::ptg_state_e state_q;
   logic [DIV_W-1:0]     divCnt_q;
   logic [4:0]           bitIdx_q;
   logic [LOOP_W-1:0]    loopsLeft_q;
   logic                 out_q;
   logic                 done_q;
   logic [DIV_W-1:0]     rateMask;
   logic                 rateTick;
   logic [31:0]          effPattern;
   logic [4:0]           effLast;

   ////////////////////////////////////////////////////////////////////////////
   assign rateMask   = DIV_W'((32'd2 << rateSel) - 32'd1);
   assign rateTick   = (state_q != ptg_pkg::PTG_IDLE) && modEn && ((divCnt_q & rateMask) == rateMask);
   // a square wave is the two-bit pattern 0,1 so it toggles on every tick
   assign effPattern = squareMode ? ptg_pkg::PTG_SQ_PATTERN : pattern;
   assign effLast    = squareMode ? ptg_pkg::PTG_SQ_LAST :
                       ((lastBit == 5'h00) ? ptg_pkg::PTG_MIN_LAST : lastBit);
   assign running    = (state_q != ptg_pkg::PTG_IDLE);
   assign chanOut    = out_q;
   assign done       = done_q;

   ////////////////////////////////////////////////////////////////////////////
   // restart clears the divider so every channel started together stays in step
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         divCnt_q <= '0;
      end else if (start) begin
         divCnt_q <= '0;
      end else if (running && modEn) begin
         divCnt_q <= divCnt_q + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q     <= ptg_pkg::PTG_IDLE;
         bitIdx_q    <= '0;
         loopsLeft_q <= '0;
         out_q       <= 1'b0;
         done_q      <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (stop) begin
            state_q <= ptg_pkg::PTG_IDLE;
            out_q   <= 1'b0;
         end else if (start) begin
            state_q     <= ptg_pkg::PTG_RUN;
            bitIdx_q    <= '0;
            loopsLeft_q <= loopCount;
         end else if (rateTick) begin
            case (state_q)
               ptg_pkg::PTG_RUN: begin
                  out_q <= effPattern[bitIdx_q];
                  if (bitIdx_q >= effLast) begin
                     bitIdx_q <= '0;
                     // zero loops means repeat without end
                     if (loopsLeft_q == LOOP_W'(1)) begin
                        state_q <= ptg_pkg::PTG_DRAIN;
                     end else if (loopsLeft_q != '0) begin
                        loopsLeft_q <= loopsLeft_q - 1'b1;
                     end
                  end else begin
                     bitIdx_q <= bitIdx_q + 1'b1;
                  end
               end
               ptg_pkg::PTG_DRAIN: begin
                  // last bit got its full period, now park at idle level
                  state_q <= ptg_pkg::PTG_IDLE;
                  out_q   <= 1'b0;
                  done_q  <= 1'b1;
               end
               default: begin
                  state_q <= ptg_pkg::PTG_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_lastTick;
      rateTick && !start && !stop && state_q == ptg_pkg::PTG_RUN && bitIdx_q >= effLast
         && loopsLeft_q == LOOP_W'(1);
   endsequence

   sequence s_drainTick;
      rateTick && !start && !stop && state_q == ptg_pkg::PTG_DRAIN;
   endsequence

   a_final_loop_drain: assert property (@(posedge clock) disable iff (!resetn)
      s_lastTick |=> state_q == ptg_pkg::PTG_DRAIN)
      else $error("final loop did not enter drain");

   a_drain_done_idle: assert property (@(posedge clock) disable iff (!resetn)
      s_drainTick |=> done_q && !out_q && state_q == ptg_pkg::PTG_IDLE ##1 !done_q)
      else $error("completion not idle or done not a pulse");

   a_bit_lsb_first: assert property (@(posedge clock) disable iff (!resetn)
      (rateTick && !start && !stop && state_q == ptg_pkg::PTG_RUN) |=> out_q == $past(effPattern[bitIdx_q]))
      else $error("pattern bit out of order");

   a_start_lockstep: assert property (@(posedge clock) disable iff (!resetn)
      (start && !stop) |=> divCnt_q == '0 && bitIdx_q == '0 && state_q == ptg_pkg::PTG_RUN)
      else $error("start did not realign channel");
endmodule : ptg_channel
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clock = 1'b0, resetn = 1'b0;
   logic [2:0]  modDiv = 3'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rd_d;
   logic [1:0]  bresp, rresp, rd_r;
   logic        awready, wready, bvalid, arready, rvalid, irq, prev;
   logic [31:0] rdata;
   logic [15:0] outs, pinEn;
   int          n_errors = 0, tests_run = 0, edges = 0, diffs = 0;
   always #4 clock = ~clock;
   ptg_pulse_train DUT (.clock(clock), .resetn(resetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .moduleClkPin(modDiv[2]), .pulse_train_outputs(outs),
      .pinFuncEn(pinEn), .irq(irq));
   // slow alternate module clock: one rising edge every eight system clocks
   always @(posedge clock) modDiv <= modDiv + 3'h1;
   // rising edges of channel 0 and lockstep misses between channels 0 and 1
   always @(posedge clock) begin
      edges = edges + int'(outs[0] & ~prev);
      diffs = diffs + int'(outs[0] !== outs[1]);
      prev  = outs[0];
   end
   ////////////////////////////////////////////////////////////////////////////
   // ready is sampled at the falling edge so the decision matches the rising edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] t;
      logic       b;
      b = 1'b0;
      @(posedge clock);
      {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
      while (!b) begin
         @(negedge clock);
         t = {awvalid & awready, wvalid & wready};
         b = bvalid;
         @(posedge clock);
         awvalid <= awvalid & ~t[1];
         wvalid  <= wvalid & ~t[0];
      end
   endtask : wr
   task automatic rd(input logic [11:0] a);
      logic t, b;
      b = 1'b0;
      @(posedge clock);
      {araddr, arvalid} <= {a, 1'b1};
      while (!b) begin
         @(negedge clock);
         t    = arvalid & arready;
         b    = rvalid;
         rd_d = rdata;
         rd_r = rresp;
         @(posedge clock);
         arvalid <= arvalid & ~t;
      end
   endtask : rd
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic waitStat(input logic [31:0] m);
      repeat (80) begin
         rd(ptg_pkg::PTG_OFF_INTSTAT);
         if ((rd_d & m) === m) break;
      end
   endtask : waitStat
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(12'h130);
      cmp(rd_d, ptg_pkg::PTG_CFG_RST);
      rd(12'h0f0);
      cmp({30'h0, rd_r}, {30'h0, ptg_pkg::PTG_RESP_SLVERR});
      wr(12'h0f4, 32'h1);
      cmp({30'h0, bresp}, {30'h0, ptg_pkg::PTG_RESP_SLVERR});
      wr(ptg_pkg::PTG_OFF_PINEN, 32'h3);
      cmp({16'h0, pinEn}, 32'h3);
      $display("test regs done");
   endtask : t_regs
   // pattern 101010 lsb first gives three rising edges per loop
   task automatic t_shot(input logic [31:0] loops, input int expEdges);
      wr(ptg_pkg::PTG_OFF_INTCLR, 32'hffff);
      wr(12'h100, 32'h0000_0500);
      wr(12'h104, 32'h0000_0015);
      wr(12'h108, loops);
      edges = 0;
      wr(ptg_pkg::PTG_OFF_START, 32'h1);
      waitStat(32'h1);
      cmp(32'(edges), 32'(expEdges));
      cmp({31'h0, outs[0]}, 32'h0);
      rd(ptg_pkg::PTG_OFF_RUNNING);
      cmp(rd_d & 32'h1, 32'h0);
      $display("test shot done");
   endtask : t_shot
   task automatic t_irq;
      wr(ptg_pkg::PTG_OFF_INTEN, 32'h0);
      cmp({31'h0, irq}, 32'h0);
      wr(ptg_pkg::PTG_OFF_INTEN, 32'h1);
      rd(ptg_pkg::PTG_OFF_INTSTAT);
      cmp({31'h0, irq}, 32'h1);
      wr(ptg_pkg::PTG_OFF_INTCLR, 32'h1);
      rd(ptg_pkg::PTG_OFF_INTSTAT);
      cmp(rd_d, 32'h0);
      cmp({31'h0, irq}, 32'h0);
      $display("test irq done");
   endtask : t_irq
   task automatic t_group;
      wr(12'h110, 32'h0000_0500);
      wr(12'h114, 32'h0000_0015);
      wr(12'h118, 32'h2);
      wr(12'h108, 32'h2);
      diffs = 0;
      wr(ptg_pkg::PTG_OFF_START, 32'h3);
      waitStat(32'h3);
      cmp(32'(diffs), 32'h0);
      wr(ptg_pkg::PTG_OFF_INTCLR, 32'h3);
      wr(12'h118, 32'h1);
      wr(12'h108, 32'h0002_0001);
      wr(ptg_pkg::PTG_OFF_START, 32'h1);
      waitStat(32'h3);
      cmp(rd_d & 32'h3, 32'h3);
      $display("test group done");
   endtask : t_group
   // square wave at divide by four rises every eight clocks; then stop, then slow module clock
   task automatic t_modes;
      wr(ptg_pkg::PTG_OFF_INTCLR, 32'hffff);
      wr(12'h100, 32'h0000_0011);
      wr(12'h108, 32'h0);
      wr(ptg_pkg::PTG_OFF_START, 32'h1);
      edges = 0;
      repeat (44) @(posedge clock);
      cmp(32'(edges), 32'h5);
      wr(ptg_pkg::PTG_OFF_STOP, 32'h1);
      rd(ptg_pkg::PTG_OFF_RUNNING);
      cmp(rd_d & 32'h1, 32'h0);
      cmp({31'h0, outs[0]}, 32'h0);
      wr(12'h100, 32'h0000_0500);
      wr(12'h108, 32'h1);
      wr(ptg_pkg::PTG_OFF_CTRL, 32'h1);
      edges = 0;
      wr(ptg_pkg::PTG_OFF_START, 32'h1);
      repeat (60) @(posedge clock);
      rd(ptg_pkg::PTG_OFF_INTSTAT);
      cmp(rd_d & 32'h1, 32'h0);
      waitStat(32'h1);
      cmp(32'(edges), 32'h3);
      wr(ptg_pkg::PTG_OFF_CTRL, 32'h0);
      $display("test modes done");
   endtask : t_modes
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   initial begin
      #100000;
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      t_regs();
      t_shot(32'h1, 3);
      t_shot(32'h2, 6);
      t_irq();
      t_group();
      t_modes();
      finish_test();
   end
endmodule : testbench
`default_nettype wire
